/* File: verilog/cmpu_top.sv */
// Purpose: decode and execute four compare operations behind APB
// Assumes: software loads opcode, extension words and fetched operands
// Notes: one-cycle execution; flags kept in the ccr register
//
// Register access over APB and the register offsets are this design's own decisions.
`default_nettype none

module cmpu_top (
  input wire logic pclk, // core clock, 100 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output cmpu_pkg::cmpu_ccr_t ccr_out, // current condition flags
  output logic exec_done // one-cycle pulse per executed compare
);
  import cmpu_pkg::*;

  typedef enum logic {ST_IDLE, ST_EXEC} cmpu_state_t;

  cmpu_state_t state_r;
  logic [15:0] opcode_r;
  logic [31:0] ext_r;
  logic [31:0] dst_r;
  logic [31:0] src_r;
  logic [31:0] lower_r;
  logic [31:0] upper_r;
  cmpu_ccr_t ccr_r;
  cmpu_ccr_t ccr_nxt;
  logic done_r;
  logic ill_r;
  logic exec_done_r;
  logic [31:0] prdata_r;
  cmpu_dec_t dec;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic start;
  logic [31:0] rd_mux;
  logic [2:0] step;
  logic [31:0] imm_val;
  logic [31:0] sub_a;
  logic [31:0] sub_b;
  logic [1:0] sub_size;
  cmpu_ccr_t sub_flags;
  logic [31:0] bv;
  logic [31:0] blo;
  logic [31:0] bhi;
  logic b_signed;
  logic b_out;
  logic b_eq;

  function automatic logic [31:0] sext(input logic [31:0] val,
                                       input logic [1:0] sz);
    logic [31:0] r;
    r = val;
    if (sz == SZ_BYTE) begin
      r = {{24{val[7]}}, val[7:0]};
    end else if (sz == SZ_WORD) begin
      r = {{16{val[15]}}, val[15:0]};
    end
    return r;
  endfunction

  // ---------------- apb slave ----------------
  assign pready = 1'b1; // zero wait states, read data latched in setup
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL: rd_mux = 32'h0000_0000;
      OFS_OPCODE: rd_mux = {16'h0000, opcode_r};
      OFS_EXT: rd_mux = ext_r;
      OFS_DST: rd_mux = dst_r;
      OFS_SRC: rd_mux = src_r;
      OFS_LOWER: rd_mux = lower_r;
      OFS_UPPER: rd_mux = upper_r;
      OFS_CCR: rd_mux = {27'h0, ccr_r};
      OFS_STATUS: begin
        rd_mux[ST_BUSY_BIT] = (state_r == ST_EXEC);
        rd_mux[ST_DONE_BIT] = done_r;
        rd_mux[ST_ILL_BIT] = ill_r;
        rd_mux[ST_STEP_LSB +: 3] = step;
      end
      OFS_DECODE: rd_mux = {13'h0, dec};
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_r <= rd_mux;
    end
  end
  assign prdata = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode_r <= 16'h0000;
      ext_r <= 32'h0000_0000;
      dst_r <= 32'h0000_0000;
      src_r <= 32'h0000_0000;
      lower_r <= 32'h0000_0000;
      upper_r <= 32'h0000_0000;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_OPCODE: opcode_r <= pwdata[15:0];
        OFS_EXT: ext_r <= pwdata;
        OFS_DST: dst_r <= pwdata;
        OFS_SRC: src_r <= pwdata;
        OFS_LOWER: lower_r <= pwdata;
        OFS_UPPER: upper_r <= pwdata;
        default: ;
      endcase
    end
  end

  // start ignored while a compare is executing
  assign start = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_START_BIT]
                 && (state_r == ST_IDLE);

  // ---------------- decode ----------------
  always_comb begin
    dec = '0;
    dec.kind = K_NONE;
    dec.illegal = 1'b1;
    dec.ea_mode = opcode_r[5:3];
    dec.ea_reg = opcode_r[2:0];
    if (opcode_r[15:12] == OP_GRP_CMP && (opcode_r[8:6] == OPM_ADDR_W
        || opcode_r[8:6] == OPM_ADDR_L)) begin
      dec.kind = K_ADDR;
      dec.size = opcode_r[8] ? SZ_LONG : SZ_WORD;
      dec.dst_reg = opcode_r[11:9];
      dec.reg_class = 1'b1;
      dec.illegal = (dec.ea_mode == EA_EXT)
                    && (dec.ea_reg > EXT_IMM);
    end else if (opcode_r[15:12] == OP_GRP_CMP && opcode_r[8]
                 && opcode_r[5:3] == MEMPAIR_MODE) begin
      dec.kind = K_MEMPAIR;
      dec.size = opcode_r[7:6];
      dec.dst_reg = opcode_r[11:9];
      dec.src_reg = opcode_r[2:0];
      dec.illegal = (opcode_r[7:6] == SZ_BAD);
    end else if (opcode_r[15:8] == OP_IMM_HI) begin
      dec.kind = K_IMM;
      dec.size = opcode_r[7:6];
      dec.illegal = (opcode_r[7:6] == SZ_BAD)
                    || (dec.ea_mode == EA_AREG)
                    || (dec.ea_mode == EA_EXT
                        && dec.ea_reg >= EXT_IMM);
    end else if (opcode_r[15:11] == OP_BND_HI
                 && opcode_r[8:6] == BND_FIX) begin
      dec.kind = K_BOUNDS;
      dec.size = opcode_r[10:9];
      dec.reg_class = ext_r[EXT_CLASS_BIT];
      dec.dst_reg = ext_r[EXT_REG_MSB:EXT_REG_LSB];
      // trap bit set means the trapping check, not handled here
      dec.illegal = (opcode_r[10:9] == SZ_BAD) || ext_r[EXT_TRAP_BIT]
                    || !(dec.ea_mode == EA_IND || dec.ea_mode == EA_D16
                         || dec.ea_mode == EA_IDX
                         || (dec.ea_mode == EA_EXT
                             && dec.ea_reg <= EXT_PCIDX));
    end
  end

  // pointer step for the memory pair; the core applies it to both
  always_comb begin
    unique case (dec.size)
      SZ_BYTE: step = STEP_B;
      SZ_WORD: step = STEP_W;
      default: step = STEP_L;
    endcase
    if (dec.kind != K_MEMPAIR) begin
      step = 3'h0;
    end
  end

  // immediate operand from extension words, first word in ext[31:16]
  always_comb begin
    unique case (dec.size)
      SZ_BYTE: imm_val = {24'h000000, ext_r[23:16]};
      SZ_WORD: imm_val = {16'h0000, ext_r[31:16]};
      default: imm_val = ext_r;
    endcase
  end

  // ---------------- arithmetic compares ----------------
  always_comb begin
    sub_a = dst_r;
    sub_b = src_r;
    sub_size = dec.size;
    unique case (dec.kind)
      K_ADDR: begin
        // word source widened, then all 32 register bits compared
        if (dec.ea_mode == EA_EXT && dec.ea_reg == EXT_IMM) begin
          sub_b = imm_val;
        end
        sub_b = sext(sub_b, dec.size);
        sub_size = SZ_LONG;
      end
      K_IMM: sub_b = imm_val;
      default: ;
    endcase
  end

  cmpu_flag_eval u_flag (
    .minuend(sub_a),
    .subtrahend(sub_b),
    .size(sub_size),
    .flags(sub_flags)
  );

  // ---------------- bounds compare ----------------
  always_comb begin
    if (dec.reg_class) begin
      bv = dst_r;
      blo = sext(lower_r, dec.size);
      bhi = sext(upper_r, dec.size);
    end else begin
      // low part moved to the top so ordering uses chosen width
      unique case (dec.size)
        SZ_BYTE: begin
          bv = {dst_r[7:0], 24'h000000};
          blo = {lower_r[7:0], 24'h000000};
          bhi = {upper_r[7:0], 24'h000000};
        end
        SZ_WORD: begin
          bv = {dst_r[15:0], 16'h0000};
          blo = {lower_r[15:0], 16'h0000};
          bhi = {upper_r[15:0], 16'h0000};
        end
        default: begin
          bv = dst_r;
          blo = lower_r;
          bhi = upper_r;
        end
      endcase
    end
    // logically larger lower bound means a signed pair
    b_signed = (blo > bhi);
    if (b_signed) begin
      b_out = ($signed(bv) < $signed(blo)) || ($signed(bv) > $signed(bhi));
    end else begin
      b_out = (bv < blo) || (bv > bhi);
    end
    b_eq = (bv == blo) || (bv == bhi);
  end

  // ---------------- execution ----------------
  always_comb begin
    ccr_nxt = ccr_r; // extend bit never written by a compare
    if (!dec.illegal) begin
      if (dec.kind == K_BOUNDS) begin
        ccr_nxt.z = b_eq;
        ccr_nxt.c = b_out;
      end else begin
        ccr_nxt.n = sub_flags.n;
        ccr_nxt.z = sub_flags.z;
        ccr_nxt.v = sub_flags.v;
        ccr_nxt.c = sub_flags.c;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: if (start) state_r <= ST_EXEC;
        ST_EXEC: state_r <= ST_IDLE;
      endcase
    end
  end

  // execution wins over a software write to the flags in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccr_r <= CCR_RST;
    end else if (state_r == ST_EXEC) begin
      ccr_r <= ccr_nxt;
    end else if (wr_en && paddr == OFS_CCR) begin
      ccr_r <= pwdata[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
      ill_r <= 1'b0;
      exec_done_r <= 1'b0;
    end else begin
      exec_done_r <= (state_r == ST_EXEC);
      if (state_r == ST_EXEC) begin
        done_r <= 1'b1;
        ill_r <= dec.illegal;
      end else if (start) begin
        done_r <= 1'b0;
      end
    end
  end

  assign ccr_out = ccr_r;
  assign exec_done = exec_done_r;

  // ---------------- assertions ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic exec_ok;
  assign exec_ok = (state_r == ST_EXEC) && !dec.illegal;

  extend_kept_a: assert property (
    (state_r == ST_EXEC) |=> ccr_r.x == $past(ccr_r.x))
    else $error("extend flag changed by a compare");

  addr_word_ext_a: assert property (
    exec_ok && dec.kind == K_ADDR && dec.size == SZ_WORD
    && dec.ea_mode != EA_EXT && dst_r == sext(src_r, SZ_WORD)
    |=> ccr_r.z && !ccr_r.c)
    else $error("word address compare not sign-extended");

  imm_byte_eq_a: assert property (
    exec_ok && dec.kind == K_IMM && dec.size == SZ_BYTE
    && dst_r[7:0] == ext_r[23:16] |=> ccr_r.z)
    else $error("byte immediate not taken from low byte");

  illegal_kept_a: assert property (
    (state_r == ST_EXEC) && dec.illegal
    |=> ccr_r == $past(ccr_r))
    else $error("illegal compare altered flags");

  bound_nv_kept_a: assert property (
    exec_ok && dec.kind == K_BOUNDS
    |=> ccr_r.n == $past(ccr_r.n) && ccr_r.v == $past(ccr_r.v))
    else $error("bounds compare touched n or v");

  single_value_a: assert property (
    exec_ok && dec.kind == K_BOUNDS && blo == bhi && bv == blo
    |=> ccr_r.z && !ccr_r.c)
    else $error("equal bounds value judged out of range");

  pair_step_a: assert property (
    dec.kind == K_MEMPAIR && dec.size == SZ_LONG |-> step == STEP_L)
    else $error("long memory pair step not four");

  byte_borrow_a: assert property (
    exec_ok && dec.kind == K_MEMPAIR && dec.size == SZ_BYTE
    && dst_r[7:0] < src_r[7:0] |=> ccr_r.c)
    else $error("byte borrow not seen");

  unsigned_out_a: assert property (
    exec_ok && dec.kind == K_BOUNDS && !b_signed && bv > bhi
    |=> ccr_r.c)
    else $error("value above upper bound not flagged");

  start_done_a: assert property (
    start |=> state_r == ST_EXEC ##1 exec_done && state_r == ST_IDLE)
    else $error("compare did not finish in two cycles");

  cov_addr_c: cover property (exec_ok && dec.kind == K_ADDR);
  cov_imm_c: cover property (exec_ok && dec.kind == K_IMM);
  cov_pair_c: cover property (exec_ok && dec.kind == K_MEMPAIR);
  cov_bound_out_c: cover property (exec_ok && dec.kind == K_BOUNDS && b_out);
endmodule // cmpu_top

`default_nettype wire

/* File: verilog/cmpu_pkg.sv */
// Purpose: constants, fields and types of the compare instruction unit
// Assumes: 32-bit APB register window, one aligned word per register
// Notes: opcode and extension words are loaded by software before start
//
// Function
// - address compare: register minus source, register kept
// - opmode 011 word sign-extended, 111 long
// - X untouched; N Z V C from difference
// - address compare: reg 11:9, opmode 8:6, ea 5:0
// - address compare accepts all modes, immediate 111/100
// - immediate compare: destination minus immediate, no write
// - size field 00 byte, 01 word, 10 long
// - immediate from extension words by size
// - immediate compare: data modes, no An, no immediate
// - memory pair: postincrement both pointers, memory kept
// - memory pair: dst 11:9, size 7:6, src 2:0
// - bounds pair: lower first, then upper
// - data register byte/word: low part only
// - address register byte/word: bounds sign-extended
// - equal bounds: single value in range
// - out of range sets flags, never traps
// - bounds: Z on equal, C out of range
// - extension word: class bit and register number
// - bounds pair: control addressing modes only
`default_nettype none

package cmpu_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OPCODE = 8'h04;
  localparam logic [7:0] OFS_EXT = 8'h08;
  localparam logic [7:0] OFS_DST = 8'h0c;
  localparam logic [7:0] OFS_SRC = 8'h10;
  localparam logic [7:0] OFS_LOWER = 8'h14;
  localparam logic [7:0] OFS_UPPER = 8'h18;
  localparam logic [7:0] OFS_CCR = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_DECODE = 8'h24;
  localparam int CTRL_START_BIT = 0;
  // status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_ILL_BIT = 2;
  localparam int ST_STEP_LSB = 4;
  localparam logic [4:0] CCR_RST = 5'h00;
  // opcode fields
  localparam logic [3:0] OP_GRP_CMP = 4'hb;
  localparam logic [2:0] OPM_ADDR_W = 3'h3;
  localparam logic [2:0] OPM_ADDR_L = 3'h7;
  localparam logic [7:0] OP_IMM_HI = 8'h0c;
  localparam logic [2:0] MEMPAIR_MODE = 3'h1;
  localparam logic [4:0] OP_BND_HI = 5'h00;
  localparam logic [2:0] BND_FIX = 3'h3;
  // extension word of bounds compare (first word in ext[31:16])
  localparam int EXT_CLASS_BIT = 31;
  localparam int EXT_REG_MSB = 30;
  localparam int EXT_REG_LSB = 28;
  localparam int EXT_TRAP_BIT = 27;
  // sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_BAD = 2'h3;
  // ea modes and mode-7 registers
  localparam logic [2:0] EA_DREG = 3'h0;
  localparam logic [2:0] EA_AREG = 3'h1;
  localparam logic [2:0] EA_IND = 3'h2;
  localparam logic [2:0] EA_D16 = 3'h5;
  localparam logic [2:0] EA_IDX = 3'h6;
  localparam logic [2:0] EA_EXT = 3'h7;
  localparam logic [2:0] EXT_PCIDX = 3'h3;
  localparam logic [2:0] EXT_IMM = 3'h4;
  // postincrement steps
  localparam logic [2:0] STEP_B = 3'h1;
  localparam logic [2:0] STEP_W = 3'h2;
  localparam logic [2:0] STEP_L = 3'h4;

  typedef enum logic [2:0] {
    K_NONE, K_ADDR, K_IMM, K_MEMPAIR, K_BOUNDS
  } cmpu_kind_t;

  typedef struct packed {
    logic x;
    logic n;
    logic z;
    logic v;
    logic c;
  } cmpu_ccr_t;

  typedef struct packed {
    cmpu_kind_t kind;
    logic [1:0] size;
    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
    logic [2:0] dst_reg;
    logic [2:0] src_reg;
    logic reg_class;
    logic illegal;
  } cmpu_dec_t;
endpackage : cmpu_pkg

`default_nettype wire

/* File: verilog/cmpu_flag_eval.sv */
// Purpose: subtract and flag evaluation at byte, word or long width
// Assumes: operands right-aligned in 32 bits
// Notes: combinational; x field always zero, caller keeps extend
`default_nettype none

module cmpu_flag_eval (
  input wire logic [31:0] minuend, // destination operand
  input wire logic [31:0] subtrahend, // source operand
  input wire logic [1:0] size, // operation size code
  output cmpu_pkg::cmpu_ccr_t flags // n z v c of the difference
);
  import cmpu_pkg::*;

  logic [4:0] sh;
  logic [31:0] a_al;
  logic [31:0] b_al;
  logic [32:0] diff;

  // align msb of chosen width to bit 31, so one 32-bit subtract serves all
  always_comb begin
    unique case (size)
      SZ_BYTE: sh = 5'h18;
      SZ_WORD: sh = 5'h10;
      default: sh = 5'h00;
    endcase
  end

  always_comb begin
    a_al = minuend << sh;
    b_al = subtrahend << sh;
    diff = {1'b0, a_al} - {1'b0, b_al};
    flags.x = 1'b0;
    flags.n = diff[31];
    flags.z = (diff[31:0] == 32'h0000_0000);
    flags.v = (a_al[31] != b_al[31]) && (diff[31] != a_al[31]);
    flags.c = diff[32];
  end
endmodule // cmpu_flag_eval

`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: self-checking bench for the compare instruction unit over apb
// Assumes: zero-wait apb slave, flags settle two edges after start
// Notes: random address, immediate and memory pair compares plus corners
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cmpu_pkg::*;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, exec_done;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  cmpu_ccr_t ccr_out;
  int err_count = 0;
  int checks_done = 0;
  int exec_cnt = 0;

  cmpu_top u_cmpu_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ccr_out(ccr_out),
    .exec_done(exec_done)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (exec_done === 1'b1) exec_cnt <= exec_cnt + 1;
  end

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic cmp_ccr(input logic [4:0] got, input logic [4:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: flags %b, wanted %b", $time, got, exp);
    end
  endtask

  // hold the request until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  task automatic run(input logic [15:0] op, input logic [31:0] ext, dst,
                     src, lo, hi, input logic [4:0] pre);
    wr(OFS_OPCODE, {16'h0, op});
    wr(OFS_EXT, ext);
    wr(OFS_DST, dst);
    wr(OFS_SRC, src);
    wr(OFS_LOWER, lo);
    wr(OFS_UPPER, hi);
    wr(OFS_CCR, {27'h0, pre});
    wr(OFS_CTRL, 32'h1);
    repeat (4) @(posedge pclk);
  endtask

  task automatic chk(input logic [15:0] op, input logic [31:0] ext, dst,
                     src, lo, hi, input logic [4:0] pre, exp,
                     input logic [2:0] kind);
    int c0;
    logic [31:0] r;
    c0 = exec_cnt;
    run(op, ext, dst, src, lo, hi, pre);
    cmp_ccr(ccr_out, exp);
    rd(OFS_STATUS, r);
    cmp_word({29'h0, r[2:0]}, 32'h2);
    rd(OFS_DECODE, r);
    cmp_word({29'h0, r[18:16]}, {29'h0, kind});
    cmp_word(32'(exec_cnt - c0), 32'h1);
  endtask

  // refused encodings leave the flags alone and flag the decode
  task automatic bad(input logic [15:0] op, input logic [31:0] ext);
    logic [31:0] r;
    run(op, ext, 32'h5, 32'h7, 32'h1, 32'h9, 5'h15);
    cmp_ccr(ccr_out, 5'h15);
    rd(OFS_STATUS, r);
    cmp_word({31'h0, r[2]}, 32'h1);
  endtask

  function automatic logic [3:0] sub_flags(logic [31:0] a, logic [31:0] b,
                                            int w);
    logic [31:0] m;
    logic [32:0] d;
    m = (w == 32) ? 32'hffffffff : ((32'h1 << w) - 32'h1);
    d = {1'b0, a & m} - {1'b0, b & m};
    return {d[w-1], (d[31:0] & m) == 32'h0,
            (a[w-1] != b[w-1]) && (d[w-1] != a[w-1]), d[32]};
  endfunction

  // top-align narrow data-register values, sign-extend address-register bounds, so one signed or unsigned compare serves all
  function automatic logic [1:0] bnd_exp(logic [1:0] sz, logic cls,
                                         logic [31:0] v, lo, hi);
    int sh;
    logic [31:0] a, l, h;
    logic lt, gt;
    sh = (sz == SZ_BYTE) ? 24 : ((sz == SZ_WORD) ? 16 : 0);
    if (cls) begin
      a = v;
      l = $signed(lo << sh) >>> sh;
      h = $signed(hi << sh) >>> sh;
    end else begin
      a = v << sh;
      l = lo << sh;
      h = hi << sh;
    end
    if (l > h) begin
      lt = $signed(a) < $signed(l);
      gt = $signed(a) > $signed(h);
    end else begin
      lt = a < l;
      gt = a > h;
    end
    return {(a == l) || (a == h), lt || gt};
  endfunction

  task automatic bnd(input logic [1:0] sz, input logic cls,
                     input logic [31:0] v, lo, hi);
    logic [1:0] zc;
    zc = bnd_exp(sz, cls, v, lo, hi);
    chk({5'h00, sz, BND_FIX, EA_IND, 3'h3}, {cls, 3'h5, 28'h0}, v,
        32'h0, lo, hi, 5'h1a, {2'b11, zc[1], 1'b1, zc[0]}, K_BOUNDS);
  endtask

  initial begin
    logic [31:0] r, dst, src, ext, sv;
    logic [15:0] op;
    logic [4:0] pre;
    logic [2:0] ra, rb, md, er, kind;
    logic [1:0] sz;
    logic lg, e;
    int i, w, seed;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    seed = $urandom(98076);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    cmp_ccr(ccr_out, CCR_RST);
    rd(OFS_STATUS, r);
    cmp_word(r, 32'h0);
    apb(1'b0, 8'h28, 32'h0, r, e);
    cmp_word({31'h0, e}, 32'h1);
    // word source sign-extended before a full 32-bit compare
    chk({4'hb, 3'h2, OPM_ADDR_W, EA_DREG, 3'h1}, 32'h0, 32'hffff8000,
        32'h00008000, 32'h0, 32'h0, 5'h10, 5'h14, K_ADDR);
    // byte immediate is the low byte of the first extension word
    chk({OP_IMM_HI, SZ_BYTE, EA_EXT, EXT_PCIDX}, 32'h00340078, 32'hffffff34,
        32'h0, 32'h0, 32'h0, 5'h0b, 5'h04, K_IMM);
    for (i = 0; i < 60; i++) begin
      dst = $urandom;
      src = $urandom;
      ext = $urandom;
      pre = 5'($urandom);
      sz = 2'($urandom % 3);
      ra = 3'($urandom);
      rb = 3'($urandom);
      md = 3'($urandom);
      er = 3'($urandom % 5);
      lg = 1'($urandom);
      w = (sz == SZ_BYTE) ? 8 : ((sz == SZ_WORD) ? 16 : 32);
      case ($urandom % 3)
        0: begin
          if (md != EA_EXT) er = rb;
          if (md == EA_EXT && er == EXT_IMM)
            sv = lg ? ext : {{16{ext[31]}}, ext[31:16]};
          else
            sv = lg ? src : {{16{src[15]}}, src[15:0]};
          op = {4'hb, ra, lg ? OPM_ADDR_L : OPM_ADDR_W, md, er};
          w = 32;
          kind = K_ADDR;
        end
        1: begin
          if (md == EA_AREG) md = EA_DREG;
          er = (md == EA_EXT) ? {1'b0, er[1:0]} : rb;
          sv = (sz == SZ_BYTE) ? {24'h0, ext[23:16]} :
               ((sz == SZ_WORD) ? {16'h0, ext[31:16]} : ext);
          op = {OP_IMM_HI, sz, md, er};
          kind = K_IMM;
        end
        default: begin
          sv = src;
          op = {4'hb, ra, 1'b1, sz, MEMPAIR_MODE, rb};
          kind = K_MEMPAIR;
        end
      endcase
      if ($urandom % 4 == 0) dst = sv;
      chk(op, ext, dst, src, 32'h0, 32'h0, pre,
          {pre[4], sub_flags(dst, sv, w)}, kind);
      if (kind == K_MEMPAIR) begin
        rd(OFS_STATUS, r);
        cmp_word({29'h0, r[6:4]}, 32'(w / 8));
        rd(OFS_DECODE, r);
        cmp_word({26'h0, r[7:2]}, {26'h0, ra, rb});
      end
    end
    bnd(SZ_BYTE, 1'b0, 32'hffffff05, 32'hf0, 32'h10);
    bnd(SZ_BYTE, 1'b0, 32'h00000080, 32'hf0, 32'h10);
    bnd(SZ_WORD, 1'b1, 32'h00010015, 32'h10, 32'h20);
    bnd(SZ_WORD, 1'b0, 32'hffff0015, 32'h10, 32'h20);
    bnd(SZ_LONG, 1'b0, 32'h30, 32'h30, 32'h30);
    bnd(SZ_LONG, 1'b0, 32'h31, 32'h30, 32'h30);
    bnd(SZ_WORD, 1'b1, 32'h0, 32'h8000, 32'h7fff);
    bnd(SZ_LONG, 1'b1, 32'h10, 32'h10, 32'h20);
    bad({OP_IMM_HI, SZ_WORD, EA_AREG, 3'h1}, 32'h0);
    bad({OP_IMM_HI, SZ_LONG, EA_EXT, EXT_IMM}, 32'h0);
    bad({OP_IMM_HI, SZ_BAD, EA_DREG, 3'h0}, 32'h0);
    bad({5'h00, SZ_LONG, BND_FIX, 3'h3, 3'h1}, 32'h0);
    bad({5'h00, SZ_LONG, BND_FIX, EA_DREG, 3'h1}, 32'h0);
    bad({5'h00, SZ_LONG, BND_FIX, EA_IND, 3'h1}, 32'h08000000);
    bad({4'hb, 3'h0, OPM_ADDR_L, EA_EXT, 3'h5}, 32'h0);
    bad({5'h00, SZ_BAD, BND_FIX, EA_IND, 3'h1}, 32'h0);
    wrap_up();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule // tb_top

`default_nettype wire
